// file: crtt_pkg.sv
package crtt_pkg;
	// index space
	localparam int REG_COUNT = 18;
	localparam logic [4:0] IDX_HTOTAL = 5'h00;
	localparam logic [4:0] IDX_HDISP = 5'h01;
	localparam logic [4:0] IDX_HPOS = 5'h02;
	localparam logic [4:0] IDX_SWIDTH = 5'h03;
	localparam logic [4:0] IDX_VTOTAL = 5'h04;
	localparam logic [4:0] IDX_VADJ = 5'h05;
	localparam logic [4:0] IDX_VDISP = 5'h06;
	localparam logic [4:0] IDX_VPOS = 5'h07;
	localparam logic [4:0] IDX_MODE = 5'h08;
	localparam logic [4:0] IDX_MAXRA = 5'h09;
	localparam logic [4:0] IDX_CURSOR = 5'h0A;
	//////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int HSW_LSB = 0;
	localparam int VSW_LSB = 4;
	localparam int SCAN_LSB = 0;
	localparam int CSKEW_LSB = 4;
	localparam int DSKEW_LSB = 6;
	localparam int CSTART_LSB = 0;
	localparam int CMODE_LSB = 5;
	//////////////////////////////////////////////////////////////////////////////
	// encodings and counts
	localparam logic [4:0] VSW_ZERO_WIDTH = 5'h10;
	localparam int BLINK16_BIT = 3;
	localparam int BLINK32_BIT = 4;
	localparam logic [1:0] SKEW_NONE = 2'h0;
	localparam logic [1:0] SKEW_ONE = 2'h1;
	localparam logic [1:0] SKEW_TWO = 2'h2;
	localparam logic [1:0] CUR_STEADY = 2'h0;
	localparam logic [1:0] CUR_HIDDEN = 2'h1;
	localparam logic [1:0] CUR_BLINK16 = 2'h2;
	localparam logic [1:0] CUR_BLINK32 = 2'h3;
	localparam int CHAR_CLK_NS = 20;
	typedef enum logic {crtt_v_rows, crtt_v_adjust} crtt_vphase_t;
endpackage

// file: crtt_skew.sv
`timescale 1ns/10ps
module crtt_skew (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// delay code and signal
	input wire logic [1:0] skew_code,
	input wire logic sig_in,
	output logic sig_out
);
	typedef struct packed {
		logic d1;
		logic d2;
		logic out;
	} crtt_skew_t;
	crtt_skew_t st;
	crtt_skew_t next_st;

	always_comb begin
		next_st = st;
		next_st.d1 = sig_in;
		next_st.d2 = st.d1;
		case (skew_code)
			crtt_pkg::SKEW_NONE: next_st.out = sig_in;
			crtt_pkg::SKEW_ONE: next_st.out = st.d1;
			crtt_pkg::SKEW_TWO: next_st.out = st.d2;
			default: next_st.out = 1'b0;
		endcase
		if (rst) begin
			next_st = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st <= next_st;
	end

	assign sig_out = st.out;

	//////////////////////////////////////////////////////////////////////////////
	// checks
	chk_skew_suppress: assert property (@(posedge sys_clk) disable iff (rst)
		(skew_code == 2'h3) |=> !sig_out)
		else $error("suppressed skew output went high");
	chk_skew_two_delay: assert property (@(posedge sys_clk) disable iff (rst)
		(skew_code == 2'h2 && $stable(skew_code) && !$past(rst) && !$past(rst, 2)) |=>
		sig_out == $past(sig_in, 3))
		else $error("two character skew delay wrong");
endmodule

// file: crtt_blink.sv
`timescale 1ns/10ps
module crtt_blink (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// field events and mode
	input wire logic field_tick,
	input wire logic [1:0] blink_mode,
	output logic cursor_visible
);
	typedef struct packed {
		logic [4:0] cnt;
		logic visible;
	} crtt_blink_t;
	crtt_blink_t st;
	crtt_blink_t next_st;

	always_comb begin
		next_st = st;
		if (field_tick) begin
			next_st.cnt = st.cnt + 5'h01;
		end
		// shown for first half of period
		case (blink_mode)
			crtt_pkg::CUR_STEADY: next_st.visible = 1'b1;
			crtt_pkg::CUR_HIDDEN: next_st.visible = 1'b0;
			crtt_pkg::CUR_BLINK16: next_st.visible = !next_st.cnt[crtt_pkg::BLINK16_BIT];
			default: next_st.visible = !next_st.cnt[crtt_pkg::BLINK32_BIT];
		endcase
		if (rst) begin
			next_st = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st <= next_st;
	end

	assign cursor_visible = st.visible;

	//////////////////////////////////////////////////////////////////////////////
	// checks
	chk_blink_hidden: assert property (@(posedge sys_clk) disable iff (rst)
		(blink_mode == 2'h1) |=> !cursor_visible)
		else $error("hidden cursor shown");
	chk_blink_half: assert property (@(posedge sys_clk) disable iff (rst)
		(blink_mode == 2'h3 && $stable(blink_mode) && st.cnt[4]) |-> !cursor_visible)
		else $error("cursor shown in dark half of period");
endmodule

// file: crtt_timing.sv
`timescale 1ns/10ps
module crtt_timing (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// host register port
	input wire logic bus_cs_n,
	input wire logic index_or_data_select,
	input wire logic bus_wr,
	input wire logic [7:0] bus_wdata,
	// cursor location from address logic
	input wire logic cursor_here,
	// display outputs
	output logic hsync_out,
	output logic vsync_out,
	output logic display_enable_out,
	output logic cursor_video_out,
	output logic [4:0] raster_addr,
	output logic field_odd
);
	typedef struct packed {
		logic [4:0] register_index;
		logic [7:0] horizontal_total;
		logic [7:0] horizontal_displayed;
		logic [7:0] horizontal_sync_position;
		logic [7:0] sync_pulse_widths;
		logic [6:0] vertical_total;
		logic [4:0] vertical_total_adjust;
		logic [6:0] vertical_displayed;
		logic [6:0] vertical_sync_position;
		logic [7:0] scan_mode_and_skew;
		logic [4:0] max_raster_address;
		logic [6:0] cursor_first_raster;
		logic [7:0] h_cnt;
		logic [4:0] ra;
		logic [6:0] row;
		logic [4:0] adj_cnt;
		crtt_pkg::crtt_vphase_t vphase;
		logic field;
		logic [3:0] hs_cnt;
		logic [4:0] hs_run;
		logic [3:0] hs_len;
		logic hsync;
		logic [4:0] vs_cnt;
		logic vsync;
		logic [4:0] ra_out;
		logic field_tick;
		logic disp_raw;
		logic cur_raw;
	} crtt_state_t;
	crtt_state_t st;
	crtt_state_t next_st;

	logic interlace;
	logic video;
	logic h_end;
	logic line_ref;
	logic row_end;
	logic field_done;
	logic disp_now;
	logic vs_trigger;
	logic cursor_visible;
	logic [7:0] vs_ref;
	logic [4:0] ra_first;
	logic [4:0] ra_step;
	logic [3:0] hsync_width_field;
	logic [4:0] vs_width;

	//////////////////////////////////////////////////////////////////////////////
	// decode of programmed fields
	always_comb begin
		interlace = st.scan_mode_and_skew[crtt_pkg::SCAN_LSB];
		video = interlace && st.scan_mode_and_skew[crtt_pkg::SCAN_LSB + 1];
		hsync_width_field = st.sync_pulse_widths[crtt_pkg::HSW_LSB +: 4];
		if (st.sync_pulse_widths[crtt_pkg::VSW_LSB +: 4] == 4'h0) begin
			vs_width = crtt_pkg::VSW_ZERO_WIDTH;
		end else begin
			vs_width = {1'b0, st.sync_pulse_widths[crtt_pkg::VSW_LSB +: 4]};
		end
		// odd interlace field references vsync to mid line
		if (interlace && st.field) begin
			vs_ref = {1'b0, st.horizontal_total[7:1]};
		end else begin
			vs_ref = 8'h00;
		end
		// video mode walks alternate rasters per field
		if (video) begin
			ra_first = {4'h0, st.field};
			ra_step = 5'h02;
		end else begin
			ra_first = 5'h00;
			ra_step = 5'h01;
		end
		h_end = st.h_cnt == st.horizontal_total;
		line_ref = st.h_cnt == vs_ref;
		row_end = st.ra >= st.max_raster_address;
		disp_now = (st.h_cnt < st.horizontal_displayed)
			&& (st.row < st.vertical_displayed)
			&& (st.vphase == crtt_pkg::crtt_v_rows);
		vs_trigger = line_ref && (st.vphase == crtt_pkg::crtt_v_rows)
			&& (st.row == st.vertical_sync_position) && (st.ra == ra_first) && !st.vsync;
	end

	//////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_st = st;
		field_done = 1'b0;
		next_st.field_tick = 1'b0;
		// horizontal counter
		if (h_end) begin
			next_st.h_cnt = 8'h00;
		end else begin
			next_st.h_cnt = st.h_cnt + 8'h01;
		end
		// horizontal sync
		if (st.hsync) begin
			next_st.hs_run = st.hs_run + 5'h01;
		end else begin
			next_st.hs_run = 5'h00;
		end
		if (st.h_cnt == st.horizontal_sync_position && hsync_width_field != 4'h0) begin
			next_st.hsync = 1'b1;
			next_st.hs_cnt = hsync_width_field - 4'h1;
			next_st.hs_len = hsync_width_field;
			next_st.hs_run = 5'h00;
		end else if (st.hsync) begin
			if (st.hs_cnt == 4'h0) begin
				next_st.hsync = 1'b0;
			end else begin
				next_st.hs_cnt = st.hs_cnt - 4'h1;
			end
		end
		// raster, row and adjust counting
		if (h_end) begin
			case (st.vphase)
				crtt_pkg::crtt_v_rows: begin
					if (row_end) begin
						next_st.ra = ra_first;
						if (st.row == st.vertical_total) begin
							if (st.vertical_total_adjust == 5'h00) begin
								field_done = 1'b1;
							end else begin
								next_st.vphase = crtt_pkg::crtt_v_adjust;
								next_st.adj_cnt = 5'h00;
							end
						end else begin
							next_st.row = st.row + 7'h01;
						end
					end else begin
						next_st.ra = st.ra + ra_step;
					end
				end
				crtt_pkg::crtt_v_adjust: begin
					if (st.adj_cnt == st.vertical_total_adjust - 5'h01) begin
						field_done = 1'b1;
					end else begin
						next_st.adj_cnt = st.adj_cnt + 5'h01;
					end
				end
				default: begin
					next_st.vphase = crtt_pkg::crtt_v_rows;
				end
			endcase
		end
		// field end: toggle field only in interlace
		if (field_done) begin
			next_st.row = 7'h00;
			next_st.adj_cnt = 5'h00;
			next_st.vphase = crtt_pkg::crtt_v_rows;
			next_st.field = interlace && !st.field;
			next_st.ra = (video && !st.field) ? 5'h01 : 5'h00;
			next_st.field_tick = 1'b1;
		end
		// vertical sync, counted in rasters
		if (vs_trigger) begin
			next_st.vsync = 1'b1;
			next_st.vs_cnt = vs_width - 5'h01;
		end else if (st.vsync && line_ref) begin
			if (st.vs_cnt == 5'h00) begin
				next_st.vsync = 1'b0;
			end else begin
				next_st.vs_cnt = st.vs_cnt - 5'h01;
			end
		end
		// video timing, cursor gated by display
		next_st.disp_raw = disp_now;
		next_st.cur_raw = disp_now && cursor_here && cursor_visible
			&& (st.ra >= st.cursor_first_raster[crtt_pkg::CSTART_LSB +: 5]);
		next_st.ra_out = st.ra;
		// host writes
		if (bus_wr && !bus_cs_n) begin
			if (!index_or_data_select) begin
				next_st.register_index = bus_wdata[4:0];
			end else begin
				case (st.register_index)
					crtt_pkg::IDX_HTOTAL: next_st.horizontal_total = bus_wdata;
					crtt_pkg::IDX_HDISP: next_st.horizontal_displayed = bus_wdata;
					crtt_pkg::IDX_HPOS: next_st.horizontal_sync_position = bus_wdata;
					crtt_pkg::IDX_SWIDTH: next_st.sync_pulse_widths = bus_wdata;
					crtt_pkg::IDX_VTOTAL: next_st.vertical_total = bus_wdata[6:0];
					crtt_pkg::IDX_VADJ: next_st.vertical_total_adjust = bus_wdata[4:0];
					crtt_pkg::IDX_VDISP: next_st.vertical_displayed = bus_wdata[6:0];
					crtt_pkg::IDX_VPOS: next_st.vertical_sync_position = bus_wdata[6:0];
					crtt_pkg::IDX_MODE: next_st.scan_mode_and_skew = bus_wdata;
					crtt_pkg::IDX_MAXRA: next_st.max_raster_address = bus_wdata[4:0];
					crtt_pkg::IDX_CURSOR: next_st.cursor_first_raster = bus_wdata[6:0];
					default: begin
					end
				endcase
			end
		end
		// reset clears timing only, registers kept
		if (rst) begin
			next_st.h_cnt = 8'h00;
			next_st.ra = 5'h00;
			next_st.row = 7'h00;
			next_st.adj_cnt = 5'h00;
			next_st.vphase = crtt_pkg::crtt_v_rows;
			next_st.field = 1'b0;
			next_st.hs_cnt = 4'h0;
			next_st.hs_run = 5'h00;
			next_st.hsync = 1'b0;
			next_st.vs_cnt = 5'h00;
			next_st.vsync = 1'b0;
			next_st.ra_out = 5'h00;
			next_st.field_tick = 1'b0;
			next_st.disp_raw = 1'b0;
			next_st.cur_raw = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st <= next_st;
	end

	//////////////////////////////////////////////////////////////////////////////
	// skew and blink
	crtt_skew u_disp_skew (
		.sys_clk(sys_clk),
		.rst(rst),
		.skew_code(st.scan_mode_and_skew[crtt_pkg::DSKEW_LSB +: 2]),
		.sig_in(st.disp_raw),
		.sig_out(display_enable_out)
	);

	crtt_skew u_cur_skew (
		.sys_clk(sys_clk),
		.rst(rst),
		.skew_code(st.scan_mode_and_skew[crtt_pkg::CSKEW_LSB +: 2]),
		.sig_in(st.cur_raw),
		.sig_out(cursor_video_out)
	);

	crtt_blink u_blink (
		.sys_clk(sys_clk),
		.rst(rst),
		.field_tick(field_done),
		.blink_mode(st.cursor_first_raster[crtt_pkg::CMODE_LSB +: 2]),
		.cursor_visible(cursor_visible)
	);

	assign hsync_out = st.hsync;
	assign vsync_out = st.vsync;
	assign raster_addr = st.ra_out;
	assign field_odd = st.field;

	//////////////////////////////////////////////////////////////////////////////
	// checks
	sequence vs_armed;
		vs_trigger;
	endsequence

	sequence vs_raised;
		vsync_out && st.vs_cnt == $past(vs_width) - 5'h01;
	endsequence

	chk_index_load: assert property (@(posedge sys_clk) disable iff (rst)
		(bus_wr && !bus_cs_n && !index_or_data_select) |=> st.register_index == $past(bus_wdata[4:0]))
		else $error("index register not loaded");
	chk_index_unused: assert property (@(posedge sys_clk) disable iff (rst)
		(bus_wr && !bus_cs_n && index_or_data_select && st.register_index >= 5'(crtt_pkg::REG_COUNT)) |=>
		($stable(st.horizontal_total) && $stable(st.sync_pulse_widths) && $stable(st.scan_mode_and_skew)))
		else $error("unused index changed a register");
	chk_hsync_place: assert property (@(posedge sys_clk) disable iff (rst)
		(st.h_cnt == st.horizontal_sync_position && hsync_width_field != 4'h0) |=> hsync_out)
		else $error("hsync not started at programmed position");
	chk_hsync_width: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(hsync_out) |-> st.hs_run == {1'b0, st.hs_len})
		else $error("hsync width differs from programmed width");
	chk_hsync_load: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(hsync_out) |-> st.hs_len == $past(hsync_width_field))
		else $error("hsync width not taken from register");
	chk_vsync_place: assert property (@(posedge sys_clk) disable iff (rst)
		vs_armed |=> vs_raised)
		else $error("vsync not started at programmed row");
	chk_vsync_sixteen: assert property (@(posedge sys_clk) disable iff (rst)
		($rose(vsync_out) && $past(st.sync_pulse_widths[7:4]) == 4'h0) |-> st.vs_cnt == 5'h0F)
		else $error("zero vsync width not sixteen rasters");
	chk_disp_region: assert property (@(posedge sys_clk) disable iff (rst)
		(st.h_cnt >= st.horizontal_displayed || st.row >= st.vertical_displayed) |=> !st.disp_raw)
		else $error("display enabled outside active region");
	chk_adjust_end: assert property (@(posedge sys_clk) disable iff (rst)
		(st.vphase == crtt_pkg::crtt_v_adjust && h_end && st.adj_cnt == st.vertical_total_adjust - 5'h01)
		|=> (st.row == 7'h00 && st.vphase == crtt_pkg::crtt_v_rows && st.field_tick))
		else $error("adjust rasters did not end the field");
	chk_reset_quiet: assert property (@(posedge sys_clk)
		rst |=> (st.h_cnt == 8'h00 && !hsync_out && !vsync_out && raster_addr == 5'h00 && !field_odd))
		else $error("reset left timing running");
	chk_reset_keeps: assert property (@(posedge sys_clk)
		(rst && !bus_wr) ##1 $changed(st.horizontal_total) |-> 1'b0)
		else $error("reset changed a control register");
endmodule

// file: crtt_crt_model.sv
`timescale 1ns/10ps
module crtt_crt_model (
	// clock
	input wire logic sys_clk,
	// video from the controller
	input wire logic hsync_out,
	input wire logic vsync_out,
	input wire logic display_enable_out,
	input wire logic cursor_video_out,
	// cursor cell from address logic
	input wire logic cur_en,
	output logic cursor_here
);
	int cyc = 0;
	int hs_rise = 0;
	int hs_w = 0;
	int hs_per = 0;
	int de_rise = 0;
	int de_w = 0;
	int de_to_hs = 0;
	int cu_lag = 0;
	int vs_rise = 0;
	int vs_per = 0;
	int vs_lines = 0;
	int lines = 0;
	int dr;
	logic hs_q = 0;
	logic vs_q = 0;
	logic de_q = 0;
	logic cu_q = 0;
	logic de_line = 0;
	assign cursor_here = cur_en;
	////////////////////////////////////////
	// edge timing of the raster signals
	always @(posedge sys_clk) begin
		dr = (display_enable_out && !de_q) ? cyc : de_rise;
		cyc <= cyc + 1;
		hs_q <= hsync_out;
		vs_q <= vsync_out;
		de_q <= display_enable_out;
		cu_q <= cursor_video_out;
		de_rise <= dr;
		if (display_enable_out && !de_q) de_line <= 1;
		if (!display_enable_out && de_q) de_w <= cyc - de_rise;
		if (cursor_video_out && !cu_q) cu_lag <= cyc - dr;
		if (hsync_out && !hs_q) begin
			hs_per <= cyc - hs_rise;
			hs_rise <= cyc;
			lines <= lines + 1;
			de_line <= 0;
			if (de_line) de_to_hs <= cyc - de_rise;
		end
		if (!hsync_out && hs_q) hs_w <= cyc - hs_rise;
		if (vsync_out && !vs_q) begin
			vs_per <= cyc - vs_rise;
			vs_rise <= cyc;
			lines <= 0;
		end
		if (!vsync_out && vs_q) vs_lines <= lines;
	end
endmodule

// file: tb_crtt_timing.sv
`timescale 1ns/10ps
module tb_crtt_timing;
	logic sys_clk = 0;
	logic rst = 1;
	logic bus_cs_n = 1;
	logic index_or_data_select = 0;
	logic bus_wr = 0;
	logic [7:0] bus_wdata = 8'h00;
	logic cur_en = 1;
	logic cursor_here, hsync_out, vsync_out, display_enable_out, cursor_video_out, field_odd;
	logic [4:0] raster_addr;
	logic seen, vq, fq;
	int n_mismatch = 0;
	int num_checks = 0;
	int tog, par, de_n, run, max_run, vsn;
	always #(crtt_pkg::CHAR_CLK_NS / 2) sys_clk = ~sys_clk;
	crtt_timing i_crtt_timing (
		.sys_clk(sys_clk),
		.rst(rst),
		.bus_cs_n(bus_cs_n),
		.index_or_data_select(index_or_data_select),
		.bus_wr(bus_wr),
		.bus_wdata(bus_wdata),
		.cursor_here(cursor_here),
		.hsync_out(hsync_out),
		.vsync_out(vsync_out),
		.display_enable_out(display_enable_out),
		.cursor_video_out(cursor_video_out),
		.raster_addr(raster_addr),
		.field_odd(field_odd)
	);
	crtt_crt_model i_m (
		.sys_clk(sys_clk),
		.hsync_out(hsync_out),
		.vsync_out(vsync_out),
		.display_enable_out(display_enable_out),
		.cursor_video_out(cursor_video_out),
		.cur_en(cur_en),
		.cursor_here(cursor_here)
	);
	////////////////////////////////////////
	// reporting and bus tasks
	task results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input int got, input int exp, input string what);
		num_checks++;
		if (got != exp) begin
			n_mismatch++;
			$display("ERROR %0t: %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task chk_lv(input logic [9:0] got, input logic [9:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task wr(input logic cs_n, input logic sel, input logic [7:0] d);
		bus_cs_n = cs_n;
		index_or_data_select = sel;
		bus_wdata = d;
		bus_wr = 1;
		@(posedge sys_clk);
		#1;
		bus_wr = 0;
		bus_cs_n = 1;
		@(posedge sys_clk);
		#1;
	endtask
	task prog(input logic [87:0] v);
		for (int i = 0; i < 11; i++) begin
			wr(1'b0, 1'b0, 8'(i));
			wr(1'b0, 1'b1, v[(10 - i) * 8 +: 8]);
		end
	endtask
	// counts over n whole field intervals, first partial one dropped
	task run_fields(input int n);
		int b;
		vsn = 0;
		seen = 0;
		vq = vsync_out;
		fq = field_odd;
		for (b = 0; b < 20000 && vsn <= n; b++) begin
			@(posedge sys_clk);
			#1;
			if (field_odd !== fq) tog++;
			if (display_enable_out === 1'b1) de_n++;
			if (display_enable_out === 1'b1 && raster_addr[0] !== field_odd) par++;
			if (cursor_video_out === 1'b1) seen = 1;
			if (vsync_out === 1'b1 && vq !== 1'b1) begin
				run = seen ? run + 1 : 0;
				if (vsn == 0) begin
					tog = 0;
					par = 0;
					de_n = 0;
					run = 0;
					max_run = 0;
				end
				max_run = run > max_run ? run : max_run;
				seen = 0;
				vsn++;
			end
			vq = vsync_out;
			fq = field_odd;
		end
		if (vsn <= n) begin
			n_mismatch++;
			$display("ERROR %0t: field wait timed out", $time);
			results();
		end
	endtask
	////////////////////////////////////////
	// scenarios
	task t_reset();
		int b;
		prog(88'h13_08_02_13_03_00_03_03_00_01_00);
		rst = 1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk_lv({hsync_out, vsync_out, display_enable_out, cursor_video_out, field_odd, raster_addr}, 10'h000, "reset outs");
		rst = 0;
		for (b = 0; b < 40 && hsync_out !== 1'b1; b++) begin
			@(posedge sys_clk);
			#1;
		end
		chk(b, 3, "hsync after reset");
		run_fields(2);
		chk(i_m.hs_per, 20, "line kept");
		$display("t_reset done");
	endtask
	task t_hsync();
		for (int k = 0; k < 3; k++) begin
			prog({8'h13, 8'h08, 8'h02, 4'h1, 4'(1 + 7 * k), 48'h03_00_03_03_00_01, 8'h00});
			run_fields(2);
			chk(i_m.hs_per, 20, "line length");
			chk(i_m.hs_w, 1 + 7 * k, "hsync width");
		end
		$display("t_hsync done");
	endtask
	task t_skew();
		for (int k = 0; k < 4; k++) begin
			prog(88'h13_08_0C_13_03_00_03_03_00_01_00 | (88'(k) << 22));
			run_fields(2);
			if (k == 3) begin
				chk(de_n, 0, "enable off");
			end else begin
				chk(i_m.de_to_hs, 11 - k, "enable to hsync");
				chk(i_m.de_w, 8, "enable width");
			end
			prog(88'h13_08_0C_13_03_00_03_03_00_01_00 | (88'(k) << 20));
			run_fields(2);
			chk(k == 3 ? max_run : i_m.cu_lag, k == 3 ? 0 : k, "cursor skew");
		end
		$display("t_skew done");
	endtask
	task t_vert();
		for (int k = 0; k < 3; k++) begin
			prog(88'h09_04_05_02_09_03_02_02_00_01_20 | (88'(k == 2 ? 0 : 1 + 8 * k) << 60));
			run_fields(2);
			chk(i_m.vs_per, 230, "frame length");
			chk(i_m.vs_lines, k == 2 ? 16 : 1 + 8 * k, "vsync width");
		end
		$display("t_vert done");
	endtask
	task t_scan();
		logic [1:0] m;
		for (int k = 0; k < 4; k++) begin
			m = {k[0], k[1]};
			prog(88'h09_04_05_12_04_01_03_04_00_03_20 | (88'(m) << 16));
			run_fields(4);
			chk(tog >= 3 ? 1 : tog, 32'(m[0]), "field toggles");
			if (m == 2'h3) chk(par, 0, "field parity");
		end
		$display("t_scan done");
	endtask
	task t_index();
		prog(88'h13_08_02_13_03_00_03_03_00_01_00);
		wr(1'b0, 1'b0, 8'h12);
		wr(1'b0, 1'b1, 8'h17);
		wr(1'b0, 1'b0, 8'h1F);
		wr(1'b0, 1'b1, 8'h17);
		wr(1'b1, 1'b0, 8'h03);
		wr(1'b0, 1'b1, 8'h17);
		run_fields(2);
		chk(i_m.hs_w, 3, "unused index");
		wr(1'b0, 1'b0, 8'h03);
		wr(1'b0, 1'b1, 8'h15);
		wr(1'b1, 1'b1, 8'h16);
		run_fields(2);
		chk(i_m.hs_w, 5, "indexed write");
		$display("t_index done");
	endtask
	task t_cursor();
		int e[7] = '{48, 0, 8, 16, 8, 0, 0};
		for (int k = 0; k < 7; k++) begin
			cur_en = k < 6;
			prog({80'h09_04_05_12_01_00_01_01_00_01, 1'b0, k < 4 ? 2'(k) : 2'h0, 5'(k == 4 ? 1 : k == 5 ? 2 : 0)});
			run_fields(k < 4 ? 48 : 8);
			chk(max_run, e[k], "cursor fields");
		end
		$display("t_cursor done");
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		#1;
		rst = 0;
		t_reset();
		t_hsync();
		t_skew();
		t_vert();
		t_scan();
		t_index();
		t_cursor();
		results();
	end
endmodule
